//--- design/crms_params.svh
// Purpose: named constants for the camera recorder mode sequencer
// Assumes: 50 MHz system clock, one common 250 ms sequence tick
// Notes: times are in milliseconds, converted to ticks or cycles in code
`ifndef CRMS_PARAMS_SVH
`define CRMS_PARAMS_SVH
`define CRMS_CLK_HZ 50000000
`define CRMS_TICK_MS 250
`define CRMS_PREP_MS 6500
`define CRMS_RUN_TAPE_MS 44000
`define CRMS_SHUTTER_MS 45500
`define CRMS_CYCLE_END_MS 58750
`define CRMS_PERIOD_MS 260000
`define CRMS_EXPOSE_MS 17
`define CRMS_PICTURES 4'hB
`define CRMS_MIN_STORED 2'h3
`define CRMS_ADDR_CTRL 4'h0
`define CRMS_ADDR_STATUS 4'h4
`define CRMS_ADDR_ISTAT 4'h8
`define CRMS_ADDR_IMASK 4'hC
`define CRMS_CTRL_RST 3'h0
`define CRMS_CTRL_EN 0
`define CRMS_CTRL_CAM 1
`define CRMS_CTRL_REC 2
`define CRMS_IRQ_SEQ 0
`define CRMS_IRQ_PIC 1
`define CRMS_IRQ_EOP 2
`define CRMS_IRQ_FULL 3
`endif

//--- design/crms_pkg.sv
// Purpose: shared types of the camera recorder mode sequencer
// Assumes: nothing beyond the params header
// Notes: sequence states and tick counter width
package crms_pkg;
   typedef logic [31:0] crms_word_t;
   typedef logic [10:0] crms_tick_t;
   typedef enum logic [1:0] {
      SQ_IDLE  = 2'b00,
      SQ_PREP  = 2'b01,
      SQ_CYCLE = 2'b10,
      SQ_GAP   = 2'b11
   } crms_seq_e;
endpackage

//--- design/crms_tick_if.sv
// Purpose: link between the sequence timer and the sequencer
// Assumes: single clock domain
// Notes: restart clears the divider and the tick count together
`timescale 1ns/1ps
`default_nettype none
interface crms_tick_if;
   import crms_pkg::*;
   logic restart;
   logic tick;
   crms_tick_t count;
   modport timer (input restart, output tick, output count);
   modport user (output restart, input tick, input count);
endinterface
`default_nettype wire

//--- design/crms_timer.sv
// Purpose: common sequence timer, a base tick and a tick counter
// Assumes: TICK_CYCLES clock cycles per tick
// Notes: count saturates at its top value
`timescale 1ns/1ps
`default_nettype none
module crms_timer #(
   parameter int TICK_CYCLES = 12500000
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_sys_rst,
   // timer side of the tick link
   crms_tick_if.timer tk
);
   import crms_pkg::*;
   logic [23:0] div_r, div_nxt;
   crms_tick_t cnt_r, cnt_nxt;
   logic tick_r, tick_nxt;

   // divider and tick counter next values
   always_comb begin
      div_nxt = div_r + 24'h000001;
      tick_nxt = 1'b0;
      cnt_nxt = cnt_r;
      if (div_r == 24'(TICK_CYCLES - 1)) begin
         div_nxt = 24'h000000;
         tick_nxt = 1'b1;
         if (cnt_r != 11'h7FF) begin
            cnt_nxt = cnt_r + 11'h001;
         end
      end
      if (tk.restart) begin
         div_nxt = 24'h000000;
         cnt_nxt = 11'h000;
         tick_nxt = 1'b0;
      end
   end

   // register stage
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         div_r <= 24'h000000;
         cnt_r <= 11'h000;
         tick_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tk.tick = tick_r;
   assign tk.count = cnt_r;
endmodule
`default_nettype wire

//--- design/crms_top.sv
// Purpose: power, mode and routing sequencer for two cameras, two recorders
// Assumes: ground commands and the programmer alarm arrive as clock pulses
// Notes: the alarm pulse marks the start of standby, one frame before T0
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "crms_params.svh"

// How it works
// R1: main power drops 58.75 s after each picture cycle reference time.
// R2: main power cycle restarts every 260 s until eleven pictures are taken.
// R3: standby power drops after the last picture cycle of a sequence.
// R4: sequence reruns each orbit alarm until programmer is disabled. The code ignores an alarm during playback.
// R5: playback command powers playback electronics, motor runs playback way.
// R6: ground also sends transmitter-on so playback reaches the station.
// R7: end of tape gives end-of-playback pulse, drops playback, back to record.
// R8: camera one feeds channel 1, camera two channel 3; one of each active.
// R9: playback outputs video channel 1 or 3 plus channel 2 flutter reference.
// R10: transmitter-on during a running sequence in record enters direct mode.
// R11: direct powers playback with record electronics, no motor, no preamp.
// R12: shutter open and close pulses are timed digitally from the clock.
// R13: recorder holds three sequences before playback is needed; flagged.
// R14: standby rises one 6.5 s frame before reference, held for sequence.
// R15: run tape rises 44 s after reference so motor reaches speed.
// R16: shutter open and close pulses are issued 45.5 s after reference.
// R17: one tick-driven timer; mode commands take effect on the next tick. The code holds playback until a tick in idle.
module crms_top #(
   parameter int TICK_CYCLES = `CRMS_TICK_MS * (`CRMS_CLK_HZ / 1000),
   parameter int EXPOSE_CYCLES = `CRMS_EXPOSE_MS * (`CRMS_CLK_HZ / 1000)
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_sys_rst,
   // avalon-mm slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [3:0] i_avs_byteenable,
   input wire crms_pkg::crms_word_t i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_irq,
   // programmer and ground command pulses, recorder end of tape sensors
   input wire logic i_prog_alarm,
   input wire logic i_cmd_playback,
   input wire logic i_cmd_xmtr_on,
   input wire logic i_cmd_xmtr_off,
   input wire logic [1:0] i_end_of_tape,
   // camera controls, one bit per camera; the shutter pulses are shared
   output logic [1:0] o_cam_standby,
   output logic [1:0] o_cam_main,
   output logic o_shutter_open,
   output logic o_shutter_close,
   // recorder controls, one bit per recorder
   output logic [1:0] o_rec_record_pwr,
   output logic [1:0] o_rec_motor_fwd,
   output logic [1:0] o_rec_motor_pb,
   output logic [1:0] o_rec_pb_pwr,
   output logic [1:0] o_rec_preamp,
   output logic [1:0] o_rec_direct,
   output logic [1:0] o_rec_ch1_en,
   output logic [1:0] o_rec_ch3_en,
   // playback output routing
   output logic o_pb_video_ch3,
   output logic o_pb_flutter_en,
   output logic o_end_of_playback
);
   import crms_pkg::*;
   localparam int TK_PREP = `CRMS_PREP_MS / `CRMS_TICK_MS;
   localparam int TK_RUN = `CRMS_RUN_TAPE_MS / `CRMS_TICK_MS;
   localparam int TK_SHUT = `CRMS_SHUTTER_MS / `CRMS_TICK_MS;
   localparam int TK_END = `CRMS_CYCLE_END_MS / `CRMS_TICK_MS;
   localparam int TK_PER = `CRMS_PERIOD_MS / `CRMS_TICK_MS;

   crms_tick_if tk ();
   crms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .tk(tk)
   );

   // true on the tick that brings the counter to x
   function automatic logic at_tk(input logic t, input crms_tick_t c,
                                  input int x);
      return t && (c == crms_tick_t'(x));
   endfunction

   logic [2:0] ctrl_r, ctrl_nxt;
   logic [3:0] istat_r, istat_nxt, imask_r, imask_nxt;
   logic wait_r, wait_nxt, irq_r, irq_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   crms_seq_e seq_r, seq_nxt;
   logic [3:0] pic_r, pic_nxt;
   logic stby_r, stby_nxt, main_r, main_nxt, run_r, run_nxt;
   logic sopen_r, sopen_nxt, sclose_r, sclose_nxt, exp_r, exp_nxt;
   logic [19:0] ecnt_r, ecnt_nxt;
   logic pb_r, pb_nxt, dir_r, dir_nxt, eop_r, eop_nxt;
   logic [1:0] stored_r, stored_nxt;
   logic p_alarm_r, p_alarm_nxt, p_pb_r, p_pb_nxt;
   logic p_xon_r, p_xon_nxt, p_xoff_r, p_xoff_nxt, p_eot_r, p_eot_nxt;
   logic restart, ev_seq, ev_pic, ev_full, wr_ok, en, cam, rec;

   assign en = ctrl_r[`CRMS_CTRL_EN];
   assign cam = ctrl_r[`CRMS_CTRL_CAM];
   assign rec = ctrl_r[`CRMS_CTRL_REC];
   assign wr_ok = i_avs_write && !wait_r;
   assign tk.restart = restart;

   // picture sequence: standby, main power cycles, tape and shutter timing
   always_comb begin
      seq_nxt = seq_r;
      pic_nxt = pic_r;
      stby_nxt = stby_r;
      main_nxt = main_r;
      run_nxt = run_r;
      sopen_nxt = 1'b0;
      sclose_nxt = 1'b0;
      exp_nxt = exp_r;
      ecnt_nxt = ecnt_r;
      restart = 1'b0;
      ev_seq = 1'b0;
      ev_pic = 1'b0;
      // close pulse follows open by the exposure count
      if (exp_r) begin
         ecnt_nxt = ecnt_r + 20'h00001;
         if (ecnt_r == 20'(EXPOSE_CYCLES - 1)) begin
            exp_nxt = 1'b0;
            sclose_nxt = 1'b1; // see R12
         end
      end
      unique case (seq_r)
         SQ_IDLE: begin
            if (p_alarm_r && tk.tick && !pb_r) begin
               seq_nxt = SQ_PREP;
               stby_nxt = 1'b1; // see R14
               pic_nxt = 4'h0;
               restart = 1'b1;
            end
         end
         SQ_PREP: begin
            if (at_tk(tk.tick, tk.count, TK_PREP)) begin
               seq_nxt = SQ_CYCLE;
               main_nxt = 1'b1;
               restart = 1'b1;
            end
         end
         SQ_CYCLE: begin
            if (at_tk(tk.tick, tk.count, TK_RUN)) begin
               run_nxt = 1'b1; // see R15
            end
            if (at_tk(tk.tick, tk.count, TK_SHUT)) begin
               sopen_nxt = 1'b1; // see R16
               exp_nxt = 1'b1;
               ecnt_nxt = 20'h00000;
            end
            if (at_tk(tk.tick, tk.count, TK_END)) begin
               main_nxt = 1'b0; // see R1
               run_nxt = 1'b0;
               pic_nxt = pic_r + 4'h1;
               ev_pic = 1'b1;
               seq_nxt = SQ_GAP;
               if (pic_r + 4'h1 == `CRMS_PICTURES) begin
                  stby_nxt = 1'b0; // see R3
                  seq_nxt = SQ_IDLE;
                  ev_seq = 1'b1;
               end
            end
         end
         SQ_GAP: begin
            if (at_tk(tk.tick, tk.count, TK_PER)) begin
               seq_nxt = SQ_CYCLE; // see R2
               main_nxt = 1'b1;
               restart = 1'b1;
            end
         end
      endcase
      // disabling the programmer ends the sequence at once
      if (!en) begin
         seq_nxt = SQ_IDLE; // see R4
         stby_nxt = 1'b0;
         main_nxt = 1'b0;
         run_nxt = 1'b0;
      end
   end

   // ground commands are held pending and applied on the next tick; playback waits for a tick in idle
   always_comb begin
      p_alarm_nxt = i_prog_alarm | (p_alarm_r & ~tk.tick); // see R17
      p_pb_nxt = i_cmd_playback | (p_pb_r & ~(tk.tick && seq_r == SQ_IDLE));
      p_xon_nxt = i_cmd_xmtr_on | (p_xon_r & ~tk.tick);
      p_xoff_nxt = i_cmd_xmtr_off | (p_xoff_r & ~tk.tick);
      p_eot_nxt = i_end_of_tape[rec] | (p_eot_r & ~tk.tick);
      pb_nxt = pb_r;
      dir_nxt = dir_r;
      eop_nxt = 1'b0;
      stored_nxt = stored_r;
      ev_full = 1'b0;
      if (tk.tick) begin
         if (p_pb_r && seq_r == SQ_IDLE && en) begin
            pb_nxt = 1'b1; // see R5
         end
         if (p_eot_r && pb_r) begin
            pb_nxt = 1'b0; // see R7
            eop_nxt = 1'b1;
            stored_nxt = 2'h0;
         end
         if (p_xon_r && seq_r != SQ_IDLE && !pb_r) begin
            dir_nxt = 1'b1; // see R10
         end
         if (p_xoff_r) begin
            dir_nxt = 1'b0;
         end
      end
      if (seq_nxt == SQ_IDLE) begin
         dir_nxt = 1'b0;
      end
      // count sequences on tape and flag when playback is due
      if (ev_seq && stored_r != `CRMS_MIN_STORED) begin
         stored_nxt = stored_r + 2'h1; // see R13
         ev_full = (stored_r + 2'h1 == `CRMS_MIN_STORED);
      end
   end

   // avalon slave: one wait cycle, then the answer; sticky w1c status
   always_comb begin
      ctrl_nxt = ctrl_r;
      imask_nxt = imask_r;
      istat_nxt = istat_r;
      wait_nxt = !((i_avs_read || i_avs_write) && wait_r);
      rdata_nxt = rdata_r;
      if (wr_ok && i_avs_byteenable[0]) begin
         unique case (i_avs_address)
            `CRMS_ADDR_CTRL: ctrl_nxt = i_avs_writedata[2:0];
            `CRMS_ADDR_ISTAT: istat_nxt = istat_r & ~i_avs_writedata[3:0];
            `CRMS_ADDR_IMASK: imask_nxt = i_avs_writedata[3:0];
            default: ;
         endcase
      end
      // hardware set wins over a clear in the same cycle
      istat_nxt[`CRMS_IRQ_SEQ] = istat_nxt[`CRMS_IRQ_SEQ] | ev_seq;
      istat_nxt[`CRMS_IRQ_PIC] = istat_nxt[`CRMS_IRQ_PIC] | ev_pic;
      istat_nxt[`CRMS_IRQ_EOP] = istat_nxt[`CRMS_IRQ_EOP] | eop_nxt;
      istat_nxt[`CRMS_IRQ_FULL] = istat_nxt[`CRMS_IRQ_FULL] | ev_full;
      irq_nxt = |(istat_nxt & imask_nxt);
      if (i_avs_read && wait_r) begin
         unique case (i_avs_address)
            `CRMS_ADDR_CTRL: rdata_nxt = {29'h0, ctrl_r};
            `CRMS_ADDR_STATUS: rdata_nxt = {20'h0, main_r, stby_r, dir_r,
                                            pb_r, stored_r, pic_r, seq_r};
            `CRMS_ADDR_ISTAT: rdata_nxt = {28'h0, istat_r};
            `CRMS_ADDR_IMASK: rdata_nxt = {28'h0, imask_r};
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   // register stage for sequence, mode and bus state
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         seq_r <= SQ_IDLE;
         pic_r <= 4'h0;
         stby_r <= 1'b0;
         main_r <= 1'b0;
         run_r <= 1'b0;
         sopen_r <= 1'b0;
         sclose_r <= 1'b0;
         exp_r <= 1'b0;
         ecnt_r <= 20'h00000;
         pb_r <= 1'b0;
         dir_r <= 1'b0;
         eop_r <= 1'b0;
         stored_r <= 2'h0;
         p_alarm_r <= 1'b0;
         p_pb_r <= 1'b0;
         p_xon_r <= 1'b0;
         p_xoff_r <= 1'b0;
         p_eot_r <= 1'b0;
         ctrl_r <= `CRMS_CTRL_RST;
         istat_r <= 4'h0;
         imask_r <= 4'h0;
         wait_r <= 1'b1;
         irq_r <= 1'b0;
         rdata_r <= 32'h0;
      end else begin
         seq_r <= seq_nxt;
         pic_r <= pic_nxt;
         stby_r <= stby_nxt;
         main_r <= main_nxt;
         run_r <= run_nxt;
         sopen_r <= sopen_nxt;
         sclose_r <= sclose_nxt;
         exp_r <= exp_nxt;
         ecnt_r <= ecnt_nxt;
         pb_r <= pb_nxt;
         dir_r <= dir_nxt;
         eop_r <= eop_nxt;
         stored_r <= stored_nxt;
         p_alarm_r <= p_alarm_nxt;
         p_pb_r <= p_pb_nxt;
         p_xon_r <= p_xon_nxt;
         p_xoff_r <= p_xoff_nxt;
         p_eot_r <= p_eot_nxt;
         ctrl_r <= ctrl_nxt;
         istat_r <= istat_nxt;
         imask_r <= imask_nxt;
         wait_r <= wait_nxt;
         irq_r <= irq_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // per camera and per recorder output flops; only the selected one acts
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_unit
         logic cs, rs;
         assign cs = (cam == 1'(g));
         assign rs = (rec == 1'(g));
         always_ff @(posedge i_clock) begin
            if (i_sys_rst) begin
               o_cam_standby[g] <= 1'b0;
               o_cam_main[g] <= 1'b0;
               o_rec_record_pwr[g] <= 1'b0;
               o_rec_motor_fwd[g] <= 1'b0;
               o_rec_motor_pb[g] <= 1'b0;
               o_rec_pb_pwr[g] <= 1'b0;
               o_rec_preamp[g] <= 1'b0;
               o_rec_direct[g] <= 1'b0;
               o_rec_ch1_en[g] <= 1'b0;
               o_rec_ch3_en[g] <= 1'b0;
            end else begin
               o_cam_standby[g] <= cs && stby_nxt;
               o_cam_main[g] <= cs && main_nxt;
               o_rec_record_pwr[g] <= rs && run_nxt;
               o_rec_motor_fwd[g] <= rs && run_nxt;
               o_rec_motor_pb[g] <= rs && pb_nxt; // see R5
               o_rec_pb_pwr[g] <= rs && (pb_nxt || dir_nxt); // see R11
               o_rec_preamp[g] <= rs && pb_nxt; // see R11
               o_rec_direct[g] <= rs && dir_nxt; // see R10
               o_rec_ch1_en[g] <= rs && run_nxt && !cam; // see R8
               o_rec_ch3_en[g] <= rs && run_nxt && cam; // see R8
            end
         end
      end
   endgenerate

   // playback routing: video follows the selected camera, flutter follows playback or direct
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_pb_video_ch3 <= 1'b0;
         o_pb_flutter_en <= 1'b0;
      end else begin
         o_pb_video_ch3 <= cam; // see R9
         o_pb_flutter_en <= pb_nxt || dir_nxt; // see R9
      end
   end

   assign o_shutter_open = sopen_r;
   assign o_shutter_close = sclose_r;
   assign o_end_of_playback = eop_r;
   assign o_avs_readdata = rdata_r;
   assign o_avs_waitrequest = wait_r;
   assign o_irq = irq_r;
endmodule
`default_nettype wire

//--- verif/crms_assertions.sv
// Purpose: port checker for the mode sequencer
// Assumes: one clock, synchronous active high reset
// Notes: intervals scale with the tick and exposure parameters of the design
`timescale 1ns/1ps
`default_nettype none
module crms_assertions #(
   parameter int TICK_CYCLES = 3,
   parameter int EXPOSE_CYCLES = 2
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_sys_rst,
   // bus handshake
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   // camera pins
   input wire logic [1:0] o_cam_standby,
   input wire logic [1:0] o_cam_main,
   input wire logic o_shutter_open,
   input wire logic o_shutter_close,
   // recorder pins
   input wire logic [1:0] o_rec_record_pwr,
   input wire logic [1:0] o_rec_motor_fwd,
   input wire logic [1:0] o_rec_motor_pb,
   input wire logic [1:0] o_rec_pb_pwr,
   input wire logic [1:0] o_rec_preamp,
   input wire logic [1:0] o_rec_direct,
   input wire logic [1:0] o_rec_ch1_en,
   input wire logic [1:0] o_rec_ch3_en,
   input wire logic o_pb_flutter_en,
   input wire logic o_end_of_playback
);
   localparam int MAIN_CYC = 235 * TICK_CYCLES + 1;
   localparam int SHUT_LAG = 6 * TICK_CYCLES;
   logic [19:0] main_len_r;
   logic [19:0] main_len_nxt;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   // cycles that main power has stood so far
   always_comb begin
      main_len_nxt = (|o_cam_main) ? main_len_r + 20'h1 : 20'h0;
   end
   always_ff @(posedge i_clock) begin
      main_len_r <= i_sys_rst ? 20'h0 : main_len_nxt;
   end
   // main power interval is exactly its cycle length
   a_main_length: assert property (
      $fell(|o_cam_main) |-> main_len_r == 20'(MAIN_CYC))
      else $error("main power interval has the wrong length");
   a_main_bound: assert property (
      (|o_cam_main) |-> main_len_r < 20'(MAIN_CYC))
      else $error("main power stands too long");
   a_standby_cover: assert property (
      (|o_cam_main) |-> (o_cam_standby & o_cam_main) == o_cam_main)
      else $error("main power without standby");
   a_one_active: assert property ($onehot0(o_cam_standby) &&
      $onehot0(o_rec_record_pwr) && $onehot0(o_rec_motor_pb))
      else $error("more than one camera or recorder active");
   a_channel_route: assert property (
      (o_rec_ch1_en & o_rec_ch3_en) == 2'h0 &&
      (o_rec_ch1_en | o_rec_ch3_en) == o_rec_record_pwr)
      else $error("camera channel routing wrong");
   a_tape_first: assert property (
      $rose(|o_rec_motor_fwd) |-> ##SHUT_LAG o_shutter_open)
      else $error("shutter not at its offset after run tape");
   a_exposure_gap: assert property (
      o_shutter_open |-> ##EXPOSE_CYCLES o_shutter_close)
      else $error("shutter close not at exposure time");
   a_shutter_ready: assert property (
      o_shutter_open |-> (|o_cam_main) && (|o_rec_motor_fwd))
      else $error("shutter outside main power and run tape");
   a_playback_set: assert property ((|o_rec_motor_pb) |->
      o_rec_preamp == o_rec_motor_pb && o_pb_flutter_en &&
      (o_rec_pb_pwr & o_rec_motor_pb) == o_rec_motor_pb)
      else $error("playback power set incomplete");
   a_direct_power: assert property ((|o_rec_direct) |->
      (o_rec_pb_pwr & o_rec_direct) == o_rec_direct && o_pb_flutter_en
      && o_rec_motor_pb == 2'h0 && o_rec_preamp == 2'h0)
      else $error("direct mode power set wrong");
   a_eop_stops: assert property (o_end_of_playback |=>
      !o_end_of_playback && o_rec_motor_pb == 2'h0)
      else $error("end of playback pulse or motor stop wrong");
   a_bus_answer: assert property ((i_avs_read || i_avs_write) &&
      o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("bus answer timing wrong");
endmodule
`default_nettype wire

//--- verif/crms_cmd_model.sv
// Purpose: command subsystem and programmer stand-in
// Assumes: one clock; commands are one-cycle pulses
// Notes: tape sensor stays tripped until the playback motor stops
`timescale 1ns/1ps
`default_nettype none
module crms_cmd_model (
   // clock and motor feedback
   input wire logic i_clock,
   input wire logic [1:0] i_motor_pb,
   // command pulses and tape sensors
   output logic o_alarm,
   output logic o_playback,
   output logic o_xmtr_on,
   output logic o_xmtr_off,
   output logic [1:0] o_eot
);
   logic [3:0] cmd_r = 4'h0;
   logic [1:0] eot_r = 2'h0;
   // command lines, one bit each
   assign {o_xmtr_off, o_xmtr_on, o_playback, o_alarm} = cmd_r;
   assign o_eot = eot_r;
   // pulse lines of m for one cycle; bit 0 alarm, bit 1 playback, bit 2 xmtr on, bit 3 xmtr off
   task automatic send(input logic [3:0] m);
      @(posedge i_clock);
      cmd_r <= m;
      @(posedge i_clock);
      cmd_r <= 4'h0;
   endtask
   // trip the sensor of recorder r, hold it while its motor runs
   task automatic end_tape(input logic r);
      int n;
      @(posedge i_clock);
      eot_r[r] <= 1'b1;
      for (n = 0; n < 400 && i_motor_pb[r] !== 1'b0; n++) @(negedge i_clock);
      @(posedge i_clock);
      eot_r[r] <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- verif/crms_top_bench.sv
// Purpose: self-checking bench for the mode sequencer
// Assumes: tick shortened to 3 clocks, exposure to 2
// Notes: two full sequences, direct mode, playback to end of tape
`timescale 1ns/1ps
`default_nettype none
module crms_top_bench;
   import crms_pkg::*;
   localparam int TICK = 3;
   localparam int SEQ_LIM = 11 * 1040 * TICK;
   logic i_clock = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [3:0] i_avs_address = 4'h0;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [3:0] i_avs_byteenable = 4'hF;
   crms_word_t i_avs_writedata = 32'h0;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest, o_irq, o_shutter_open, o_shutter_close;
   logic o_pb_video_ch3, o_pb_flutter_en, o_end_of_playback;
   logic i_prog_alarm, i_cmd_playback, i_cmd_xmtr_on, i_cmd_xmtr_off;
   logic [1:0] i_end_of_tape, o_cam_standby, o_cam_main, o_rec_preamp;
   logic [1:0] o_rec_motor_fwd, o_rec_motor_pb, o_rec_pb_pwr;
   logic [1:0] o_rec_direct, o_rec_ch1_en, o_rec_ch3_en, o_rec_record_pwr;
   int fail_count = 0;
   int checks = 0;
   // 50 MHz clock
   always #10 i_clock = ~i_clock;
   // device and its command side
   crms_top #(.TICK_CYCLES(TICK), .EXPOSE_CYCLES(2)) crms_top_inst (.*);
   crms_cmd_model crms_cmd_model_inst (.i_clock(i_clock),
      .i_motor_pb(o_rec_motor_pb), .o_alarm(i_prog_alarm),
      .o_playback(i_cmd_playback), .o_xmtr_on(i_cmd_xmtr_on),
      .o_xmtr_off(i_cmd_xmtr_off), .o_eot(i_end_of_tape));
   // verdict and run end
   task automatic end_sim();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic timeout();
      fail_count++;
      $display("BAD wait expected event seen none");
      end_sim();
   endtask
   task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
      input crms_word_t d, output crms_word_t q);
      int n;
      @(posedge i_clock);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      for (n = 0; n < 50; n++) begin
         @(posedge i_clock);
         if (o_avs_waitrequest === 1'b0) break;
      end
      q = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      if (n == 50) timeout();
   endtask
   task automatic wr(input logic [3:0] a, input crms_word_t d);
      crms_word_t q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [3:0] a, input crms_word_t e);
      crms_word_t q;
      bus(1'b0, a, 32'h0, q);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task automatic irq_chk(input crms_word_t e, input logic i);
      rd_chk(4'h8, e);
      @(negedge i_clock);
      chk("irq", 32'(i), 32'(o_irq));
   endtask
   function automatic logic cond(input int s);
      case (s)
         0: return |o_cam_standby;
         2: return |o_cam_main;
         3: return |o_rec_motor_pb;
         4: return |o_rec_direct;
         5: return o_rec_direct == 2'h0;
         default: return o_end_of_playback;
      endcase
   endfunction
   // bounded wait for a pin condition, n is cycles taken
   task automatic wait_on(input int s, input int lim, output int n);
      for (n = 1; n <= lim; n++) begin
         @(negedge i_clock);
         if (cond(s) === 1'b1) break;
      end
      if (n > lim) timeout();
   endtask
   // reset values, read-only, unmapped and byte lane refusals
   task automatic test_regs();
      int i;
      for (i = 0; i < 4; i++) rd_chk(4'(4 * i), 32'h0);
      wr(4'h4, 32'hFFF);
      rd_chk(4'h4, 32'h0);
      wr(4'h2, 32'h7);
      rd_chk(4'h2, 32'h0);
      rd_chk(4'h0, 32'h0);
      wr(4'hC, 32'hF);
      i_avs_byteenable <= 4'hE;
      wr(4'hC, 32'h0);
      i_avs_byteenable <= 4'hF;
      rd_chk(4'hC, 32'hF);
   endtask
   // one full orbit sequence on camera and recorder sel
   task automatic run_seq(input logic sel, input logic dir,
      input logic [1:0] stored);
      crms_word_t q;
      int n;
      int mains;
      int shots;
      logic prev;
      wr(4'h0, {29'h0, sel, sel, 1'b1});
      crms_cmd_model_inst.send(4'h1);
      wait_on(0, 3 * TICK, n);
      wait_on(2, 30 * TICK, n);
      chk("prep time", 32'(26 * TICK + 1), 32'(n));
      if (dir) begin
         crms_cmd_model_inst.send(4'h4);
         wait_on(4, 3 * TICK, n);
         chk("direct", 32'h141, 32'({o_rec_direct, o_rec_pb_pwr,
            o_rec_motor_pb, o_rec_preamp, o_pb_flutter_en}));
         crms_cmd_model_inst.send(4'h8);
         wait_on(5, 3 * TICK, n);
      end
      prev = 1'b1;
      mains = 1;
      shots = 0;
      for (n = 0; n < SEQ_LIM && o_cam_standby !== 2'h0; n++) begin
         @(negedge i_clock);
         if (o_cam_main !== 2'h0 && !prev) mains++;
         prev = (o_cam_main !== 2'h0);
         if (o_shutter_open === 1'b1) begin
            shots++;
            chk("route", sel ? 32'h28 : 32'h11, 32'({o_cam_main,
               o_rec_ch3_en, o_rec_ch1_en}));
         end
      end
      if (n == SEQ_LIM) timeout();
      chk("pictures", 32'hB, 32'(mains));
      chk("shutters", 32'hB, 32'(shots));
      bus(1'b0, 4'h4, 32'h0, q);
      chk("stored", 32'(stored), 32'(q[7:6]));
   endtask
   // raise, clear and mask the interrupt
   task automatic test_irq();
      irq_chk(32'h3, 1'b1);
      wr(4'h8, 32'h3);
      irq_chk(32'h0, 1'b0);
      wr(4'hC, 32'h4);
   endtask
   // playback on recorder two to the end of tape
   task automatic test_playback();
      int n;
      chk("irq masked", 32'h0, 32'(o_irq));
      crms_cmd_model_inst.send(4'h6);
      wait_on(3, 3 * TICK, n);
      chk("playback", 32'h2A, 32'({o_rec_motor_pb, o_rec_preamp,
         o_rec_pb_pwr}));
      chk("pb route", 32'h3, 32'({o_pb_video_ch3,
         o_pb_flutter_en}));
      crms_cmd_model_inst.send(4'h1);
      repeat (2 * TICK) @(negedge i_clock);
      chk("alarm in playback", 32'h0, 32'(o_cam_standby));
      fork
         crms_cmd_model_inst.end_tape(1'b1);
         wait_on(6, 3 * TICK, n);
      join
      chk("after tape", 32'h0, 32'({o_rec_motor_pb, o_rec_pb_pwr,
         o_pb_flutter_en}));
      irq_chk(32'h7, 1'b1);
      wr(4'h8, 32'h4);
      irq_chk(32'h3, 1'b0);
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      test_regs();
      run_seq(1'b0, 1'b0, 2'h1);
      test_irq();
      run_seq(1'b1, 1'b1, 2'h2);
      test_playback();
      end_sim();
   end
endmodule
bind crms_top crms_assertions #(.TICK_CYCLES(TICK_CYCLES),
   .EXPOSE_CYCLES(EXPOSE_CYCLES)) crms_assertions_inst (.*);
`default_nettype wire
